// ==== rtl/chg_pkg.sv ====
package chg_pkg;

  // Register offsets
  localparam logic [7:0] A_CFG_C = 8'h03;
  localparam logic [7:0] A_CFG_D = 8'h04;
  localparam logic [7:0] A_LED = 8'h05;
  localparam logic [7:0] A_STA = 8'h06;
  localparam logic [7:0] A_STB = 8'h07;
  localparam logic [7:0] A_GENERAL_FAULT_FLAGS = 8'h08;
  localparam logic [7:0] A_CHARGER_EVENT_FLAGS = 8'h09;
  localparam logic [7:0] A_BOOST_FAULT_FLAGS = 8'h0A;

  // Reset values
  localparam logic [7:0] RST_CFG_C = 8'h8A;
  localparam logic [7:0] RST_CFG_D = 8'h40;
  localparam logic [4:0] RST_LED = 5'h1F;

  // Field positions
  localparam int B_REF = 7;
  localparam int B_POL = 6;
  localparam int B_PEN = 5;
  localparam int B_TERM = 4;
  localparam int B_LOW = 3;
  localparam int B_SRST = 7;
  localparam int B_RECHG = 3;

  // Charger mode field codes and fault groups
  localparam logic [1:0] MODE_CHG = 2'h2;
  localparam logic [7:0] CHG_FAULTS = 8'hE4;

  // Analog steps in mV
  localparam logic [12:0] VIN_BASE = 13'h1068;
  localparam logic [12:0] VIN_STEP = 13'h0050;
  localparam logic [5:0] VIN_CAP = 6'h07;
  localparam logic [12:0] CUR_BASE = 13'h000B;
  localparam logic [12:0] CUR_STEP = 13'h0002;
  localparam logic [5:0] CUR_CAP = 6'h0A;
  localparam logic [4:0] LOW_CUR_MV = 5'h03;
  localparam logic [12:0] VMAX_BASE = 13'h1068;
  localparam logic [12:0] VOUT_BASE = 13'h0DAC;
  localparam logic [12:0] V_STEP = 13'h0014;
  localparam logic [5:0] VMAX_CAP = 6'h0C;
  localparam logic [5:0] VOUT_CAP = 6'h2F;

  // Linear code to mV with saturation above the cap
  function automatic logic [12:0] f_step_mv(input logic [12:0] base, input logic [12:0] step,
                                            input logic [5:0] code, input logic [5:0] cap);
    logic [5:0] c;
    c = (code > cap) ? cap : code;
    return base + step * {7'h00, c};
  endfunction

endpackage

// ==== rtl/chg_sync3.sv ====
`timescale 1ns/1ps
`default_nettype none
module chg_sync3 #(
  parameter int W = 1
) (
  input wire logic clk_i,          // Destination clock
  input wire logic rstn_i,         // Async reset, active low
  input wire logic [W-1:0] d_i,    // Foreign level
  output logic [W-1:0] q_o         // Filtered level
);
  logic [W-1:0] s1_r, s2_r, s3_r;

  // A bit changes only once stages two and three agree
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      q_o <= '0;
    end else begin
      s1_r <= d_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
      q_o <= ((s2_r ~^ s3_r) & s3_r) | ((s2_r ^ s3_r) & q_o);
    end
  end
endmodule
`default_nettype wire

// ==== rtl/chg_limits.sv ====
`timescale 1ns/1ps
`default_nettype none
module chg_limits
  import chg_pkg::*;
(
  input wire logic low_cur_i,          // Low current enable
  input wire logic [2:0] vin_code_i,   // Input regulation code
  input wire logic [3:0] max_cur_i,    // Max current code
  input wire logic [3:0] max_volt_i,   // Max voltage code
  input wire logic [3:0] chg_code_i,   // Programmed current code
  input wire logic [5:0] vreg_code_i,  // Programmed voltage code
  output logic [12:0] vin_mv_o,        // Input regulation mV
  output logic [4:0] sense_mv_o,       // Sense voltage mV
  output logic [12:0] vreg_mv_o        // Regulation voltage mV
);
  logic [12:0] cur_max, cur_prog, v_max, v_prog;

  assign vin_mv_o = f_step_mv(VIN_BASE, VIN_STEP, {3'h0, vin_code_i}, VIN_CAP);
  assign cur_max = f_step_mv(CUR_BASE, CUR_STEP, {2'h0, max_cur_i}, CUR_CAP);
  assign cur_prog = f_step_mv(CUR_BASE, CUR_STEP, {2'h0, chg_code_i}, CUR_CAP);
  assign v_max = f_step_mv(VMAX_BASE, V_STEP, {2'h0, max_volt_i}, VMAX_CAP);
  assign v_prog = f_step_mv(VOUT_BASE, V_STEP, vreg_code_i, VOUT_CAP);

  always_comb begin
    sense_mv_o = (cur_max < cur_prog) ? cur_max[4:0] : cur_prog[4:0];
    if (low_cur_i) begin
      sense_mv_o = LOW_CUR_MV;
    end
  end

  assign vreg_mv_o = (v_max < v_prog) ? v_max : v_prog;
endmodule
`default_nettype wire

// ==== rtl/chg_regs.sv ====
`timescale 1ns/1ps
`default_nettype none
module chg_regs
  import chg_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = 7'h48
) (
  input wire logic CLK_SYS_I,            // System clock
  input wire logic RSTN_I,               // Async reset, active low
  input wire logic LINK_CLK_I,           // Link sampling clock
  input wire logic SCL_I,                // Serial clock pin
  input wire logic SDA_I,                // Serial data pin in
  output logic SDA_O,                    // Serial data out, always low
  output logic SDA_OE_O,                 // Serial data drive enable
  output logic EXT_WR_O,                 // Write strobe, outside registers
  output logic [7:0] EXT_ADDR_O,         // Access address
  output logic [7:0] EXT_WDATA_O,        // Access write data
  input wire logic [7:0] EXT_RDATA_I,    // Outside register read data
  input wire logic [1:0] CHG_MODE_I,     // Charger mode field now
  input wire logic [3:0] CHG_CODE_I,     // Programmed current code
  input wire logic [5:0] VREG_CODE_I,    // Programmed voltage code
  input wire logic BATT_SHORT_I,         // Battery below short level
  input wire logic HOST_PIN_I,           // Host request pin
  input wire logic TEMP_HOT_I,           // Die above shutdown level
  input wire logic BUS_OV_I,             // Input bus overvoltage
  input wire logic LED_OV_I,             // LED driver overvoltage
  input wire logic [7:0] CHG_EVT_I,      // Charger event levels
  input wire logic [4:0] BST_EVT_I,      // Boost fault levels
  input wire logic STANDBY_I,            // Standby mode
  input wire logic MONITOR_ON_I,         // Shunt monitor on
  input wire logic LDO_OK_I,             // LDO on, no fault
  input wire logic LED_ON_I,             // LED driver on
  input wire logic [2:0] CHG_STATE_I,    // Charger state code
  input wire logic DETECT_DONE_I,        // Line detection finished
  input wire logic DETECT_RESULT_I,      // Line detection result
  output logic SHORT_EXT_REF_O,          // External short reference on
  output logic HOST_PIN_ACTIVE_O,        // Host pin request active
  output logic TERM_EN_O,                // Termination enable
  output logic [12:0] INPUT_REG_MV_O,    // Input regulation mV
  output logic [4:0] SENSE_MV_O,         // Charge sense mV
  output logic [12:0] VREG_MV_O,         // Regulation voltage mV
  output logic [4:0] LED_LEVEL_O,        // LED feedback level
  output logic MODE_CLEAR_O,             // Clear mode field, pulse
  output logic SOFT_RESET_O              // Parameter reset, pulse
);

  // ****************************************
  // Link side: pin sampling
  // ****************************************
  typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_ACK, ST_RX, ST_TX, ST_MACK} chg_lstate_t;

  logic scl_s, sda_s, scl_d_r, sda_d_r;
  logic scl_rise, scl_fall, bus_start, bus_stop;
  chg_lstate_t lst_r;
  logic [7:0] shift_r, ptr_r, lrdata_r;
  logic [2:0] cnt_r;
  logic byte_r, first_r, rw_r, mack_r, oe_r;
  logic req_tog_r, req_wr_r;
  logic [7:0] req_addr_r, req_wdata_r;
  logic ack_s, ack_seen_r;

  chg_sync3 #(.W(2)) u_pins (
    .clk_i(LINK_CLK_I),
    .rstn_i(RSTN_I),
    .d_i({SCL_I, SDA_I}),
    .q_o({scl_s, sda_s})
  );

  always_ff @(posedge LINK_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_d_r <= scl_s;
      sda_d_r <= sda_s;
    end
  end

  assign scl_rise = scl_s & ~scl_d_r;
  assign scl_fall = ~scl_s & scl_d_r;
  assign bus_start = scl_s & scl_d_r & ~sda_s & sda_d_r;
  assign bus_stop = scl_s & scl_d_r & sda_s & ~sda_d_r;

  // ****************************************
  // Link side: byte engine
  // ****************************************
  always_ff @(posedge LINK_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      lst_r <= ST_IDLE;
      shift_r <= 8'h00;
      cnt_r <= 3'h0;
      byte_r <= 1'b0;
      first_r <= 1'b0;
      rw_r <= 1'b0;
      mack_r <= 1'b0;
      oe_r <= 1'b0;
      ptr_r <= 8'h00;
      req_tog_r <= 1'b0;
      req_wr_r <= 1'b0;
      req_addr_r <= 8'h00;
      req_wdata_r <= 8'h00;
    end else if (bus_start) begin
      lst_r <= ST_ADDR;
      cnt_r <= 3'h0;
      byte_r <= 1'b0;
      first_r <= 1'b1;
      oe_r <= 1'b0;
    end else if (bus_stop) begin
      lst_r <= ST_IDLE;
      oe_r <= 1'b0;
    end else begin
      unique case (lst_r)
        ST_IDLE: begin
          oe_r <= 1'b0;
        end
        ST_ADDR, ST_RX: begin
          if (scl_rise) begin
            shift_r <= {shift_r[6:0], sda_s};
            cnt_r <= cnt_r + 3'h1;
            byte_r <= (cnt_r == 3'h7);
          end else if (scl_fall && byte_r) begin
            byte_r <= 1'b0;
            if (lst_r == ST_ADDR) begin
              if (shift_r[7:1] == DEV_ADDR) begin
                oe_r <= 1'b1;
                rw_r <= shift_r[0];
                lst_r <= ST_ACK;
                if (shift_r[0]) begin
                  req_tog_r <= ~req_tog_r;
                  req_wr_r <= 1'b0;
                  req_addr_r <= ptr_r;
                  ptr_r <= ptr_r + 8'h01;
                end
              end else begin
                lst_r <= ST_IDLE;
              end
            end else begin
              oe_r <= 1'b1;
              lst_r <= ST_ACK;
              if (first_r) begin
                ptr_r <= shift_r;
                first_r <= 1'b0;
              end else begin
                req_tog_r <= ~req_tog_r;
                req_wr_r <= 1'b1;
                req_addr_r <= ptr_r;
                req_wdata_r <= shift_r;
                ptr_r <= ptr_r + 8'h01;
              end
            end
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            cnt_r <= 3'h0;
            if (rw_r) begin
              shift_r <= lrdata_r;
              oe_r <= ~lrdata_r[7];
              lst_r <= ST_TX;
            end else begin
              oe_r <= 1'b0;
              lst_r <= ST_RX;
            end
          end
        end
        ST_TX: begin
          if (scl_fall) begin
            cnt_r <= cnt_r + 3'h1;
            shift_r <= {shift_r[6:0], 1'b0};
            if (cnt_r == 3'h7) begin
              oe_r <= 1'b0;
              lst_r <= ST_MACK;
            end else begin
              oe_r <= ~shift_r[6];
            end
          end
        end
        ST_MACK: begin
          if (scl_rise) begin
            mack_r <= ~sda_s;
            if (sda_s) begin
              lst_r <= ST_IDLE;
            end else begin
              req_tog_r <= ~req_tog_r;
              req_wr_r <= 1'b0;
              req_addr_r <= ptr_r;
              ptr_r <= ptr_r + 8'h01;
            end
          end else if (scl_fall && mack_r) begin
            mack_r <= 1'b0;
            cnt_r <= 3'h0;
            shift_r <= lrdata_r;
            oe_r <= ~lrdata_r[7];
            lst_r <= ST_TX;
          end
        end
      endcase
    end
  end

  assign SDA_O = 1'b0;
  assign SDA_OE_O = oe_r;

  // ****************************************
  // Crossing: request toggle in, answer back
  // ****************************************
  logic req_s, req_seen_r, acc_go_r, acc_wr_r, ack_tog_r;
  logic [7:0] acc_addr_r, acc_wdata_r, rd_data_r;

  chg_sync3 #(.W(1)) u_req (
    .clk_i(CLK_SYS_I),
    .rstn_i(RSTN_I),
    .d_i(req_tog_r),
    .q_o(req_s)
  );

  chg_sync3 #(.W(1)) u_ack (
    .clk_i(LINK_CLK_I),
    .rstn_i(RSTN_I),
    .d_i(ack_tog_r),
    .q_o(ack_s)
  );

  // Request fields stay still until the next toggle
  always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      req_seen_r <= 1'b0;
      acc_go_r <= 1'b0;
      acc_wr_r <= 1'b0;
      acc_addr_r <= 8'h00;
      acc_wdata_r <= 8'h00;
    end else begin
      req_seen_r <= req_s;
      acc_go_r <= req_s ^ req_seen_r;
      if (req_s ^ req_seen_r) begin
        acc_wr_r <= req_wr_r;
        acc_addr_r <= req_addr_r;
        acc_wdata_r <= req_wdata_r;
      end
    end
  end

  always_ff @(posedge LINK_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      ack_seen_r <= 1'b0;
      lrdata_r <= 8'h00;
    end else begin
      ack_seen_r <= ack_s;
      if (ack_s ^ ack_seen_r) begin
        lrdata_r <= rd_data_r;
      end
    end
  end

  // ****************************************
  // Analog inputs
  // ****************************************
  logic short_s, pin_s, hot_s, bov_s, lov_s, stby_s, mon_s, ldo_s, led_s, dd_s, dr_s;
  logic [7:0] chg_s, chg_d_r;
  logic [4:0] bst_s, bst_d_r;
  logic [2:0] state_s;

  chg_sync3 #(.W(27)) u_ana (
    .clk_i(CLK_SYS_I),
    .rstn_i(RSTN_I),
    .d_i({BATT_SHORT_I, HOST_PIN_I, TEMP_HOT_I, BUS_OV_I, LED_OV_I, CHG_EVT_I, BST_EVT_I,
          STANDBY_I, MONITOR_ON_I, LDO_OK_I, LED_ON_I, CHG_STATE_I, DETECT_DONE_I, DETECT_RESULT_I}),
    .q_o({short_s, pin_s, hot_s, bov_s, lov_s, chg_s, bst_s,
          stby_s, mon_s, ldo_s, led_s, state_s, dd_s, dr_s})
  );

  // ****************************************
  // Configuration registers
  // ****************************************
  logic [7:0] cfg_c_r, cfg_d_r;
  logic [4:0] led_r;
  logic [3:0] general_fault_flags_rsv_r;
  logic open_r, wr_go, srst;

  assign wr_go = acc_go_r & acc_wr_r;
  assign srst = wr_go && (acc_addr_r == A_STB) && acc_wdata_r[B_SRST];
  assign EXT_WR_O = wr_go && (acc_addr_r != A_STB) && !((acc_addr_r >= A_CFG_C) && (acc_addr_r <= A_BOOST_FAULT_FLAGS));
  assign EXT_ADDR_O = acc_addr_r;
  assign EXT_WDATA_O = acc_wdata_r;

  always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      cfg_c_r <= RST_CFG_C;
      led_r <= RST_LED;
      general_fault_flags_rsv_r <= 4'h0;
    end else if (srst) begin
      cfg_c_r <= RST_CFG_C;
      led_r <= RST_LED;
      general_fault_flags_rsv_r <= 4'h0;
    end else if (wr_go) begin
      if (acc_addr_r == A_CFG_C) begin
        cfg_c_r <= acc_wdata_r;
      end
      if (acc_addr_r == A_LED) begin
        led_r <= acc_wdata_r[4:0];
      end
      if (acc_addr_r == A_GENERAL_FAULT_FLAGS) begin
        general_fault_flags_rsv_r <= acc_wdata_r[4:1];
      end
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      cfg_d_r <= RST_CFG_D;
      open_r <= 1'b1;
    end else if (short_s) begin
      cfg_d_r <= RST_CFG_D;
      open_r <= 1'b1;
    end else if (srst) begin
      cfg_d_r <= RST_CFG_D;
      open_r <= 1'b1;
    end else if (wr_go) begin
      if (acc_addr_r != A_CFG_D) begin
        open_r <= 1'b0;
      end else if (open_r) begin
        cfg_d_r <= acc_wdata_r;
      end
    end
  end

  // ****************************************
  // Flags, cleared by a read, set wins
  // ****************************************
  logic bov_r, lov_r, rd_go;
  logic [7:0] charger_event_flags_r;
  logic [4:0] boost_fault_flags_r;

  assign rd_go = acc_go_r & ~acc_wr_r;

  always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      bov_r <= 1'b0;
      lov_r <= 1'b0;
      charger_event_flags_r <= 8'h00;
      boost_fault_flags_r <= 5'h00;
    end else begin
      bov_r <= (bov_r & ~(rd_go && (acc_addr_r == A_GENERAL_FAULT_FLAGS))) | bov_s;
      lov_r <= (lov_r & ~(rd_go && (acc_addr_r == A_GENERAL_FAULT_FLAGS))) | lov_s;
      charger_event_flags_r <= (charger_event_flags_r & ~{8{rd_go && (acc_addr_r == A_CHARGER_EVENT_FLAGS)}}) | chg_s;
      boost_fault_flags_r <= (boost_fault_flags_r & ~{5{rd_go && (acc_addr_r == A_BOOST_FAULT_FLAGS)}}) | bst_s;
    end
  end

  // ****************************************
  // Protection actions
  // ****************************************
  logic [7:0] chg_rise;
  logic [4:0] bst_rise;

  assign chg_rise = chg_s & ~chg_d_r;
  assign bst_rise = bst_s & ~bst_d_r;

  always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      chg_d_r <= 8'h00;
      bst_d_r <= 5'h00;
      MODE_CLEAR_O <= 1'b0;
      SOFT_RESET_O <= 1'b0;
    end else begin
      chg_d_r <= chg_s;
      bst_d_r <= bst_s;
      SOFT_RESET_O <= srst;
      MODE_CLEAR_O <= (|(chg_rise & CHG_FAULTS)) | (|bst_rise) |
                      (chg_rise[B_RECHG] && (CHG_MODE_I == MODE_CHG));
    end
  end

  // ****************************************
  // Read mux
  // ****************************************
  logic [7:0] rd_mux;

  always_comb begin
    rd_mux = EXT_RDATA_I;
    unique case (acc_addr_r)
      A_CFG_C: rd_mux = cfg_c_r;
      A_CFG_D: rd_mux = cfg_d_r;
      A_LED: rd_mux = {3'h0, led_r};
      A_STA: rd_mux = {1'b0, stby_s, mon_s, state_s, ldo_s, led_s};
      A_STB: rd_mux = {5'h00, dd_s, dr_s, pin_s};
      A_GENERAL_FAULT_FLAGS: rd_mux = {hot_s, bov_r, 1'b0, general_fault_flags_rsv_r, lov_r};
      A_CHARGER_EVENT_FLAGS: rd_mux = charger_event_flags_r;
      A_BOOST_FAULT_FLAGS: rd_mux = {boost_fault_flags_r, 3'h0};
      default: rd_mux = EXT_RDATA_I;
    endcase
  end

  always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      rd_data_r <= 8'h00;
      ack_tog_r <= 1'b0;
    end else if (acc_go_r) begin
      ack_tog_r <= ~ack_tog_r;
      if (!acc_wr_r) begin
        rd_data_r <= rd_mux;
      end
    end
  end

  // ****************************************
  // Outputs to the analog side
  // ****************************************
  logic [12:0] vin_mv, vreg_mv;
  logic [4:0] sense_mv;

  chg_limits u_lim (
    .low_cur_i(cfg_c_r[B_LOW]),
    .vin_code_i(cfg_c_r[2:0]),
    .max_cur_i(cfg_d_r[7:4]),
    .max_volt_i(cfg_d_r[3:0]),
    .chg_code_i(CHG_CODE_I),
    .vreg_code_i(VREG_CODE_I),
    .vin_mv_o(vin_mv),
    .sense_mv_o(sense_mv),
    .vreg_mv_o(vreg_mv)
  );

  always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      SHORT_EXT_REF_O <= 1'b0;
      HOST_PIN_ACTIVE_O <= 1'b0;
      TERM_EN_O <= 1'b0;
      INPUT_REG_MV_O <= 13'h0000;
      SENSE_MV_O <= 5'h00;
      VREG_MV_O <= 13'h0000;
      LED_LEVEL_O <= 5'h00;
    end else begin
      SHORT_EXT_REF_O <= cfg_c_r[B_REF];
      HOST_PIN_ACTIVE_O <= cfg_c_r[B_PEN] & (pin_s == cfg_c_r[B_POL]);
      TERM_EN_O <= cfg_c_r[B_TERM];
      INPUT_REG_MV_O <= vin_mv;
      SENSE_MV_O <= sense_mv;
      VREG_MV_O <= vreg_mv;
      LED_LEVEL_O <= led_r;
    end
  end

endmodule
`default_nettype wire

// ==== verif/chg_regs_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none
module chg_regs_monitor
  import chg_pkg::*;
(
  input wire logic CLK_SYS_I,
  input wire logic RSTN_I,
  input wire logic [7:0] CHG_EVT_I,
  input wire logic [4:0] BST_EVT_I,
  input wire logic [1:0] CHG_MODE_I,
  input wire logic BATT_SHORT_I,
  input wire logic [12:0] INPUT_REG_MV_O,
  input wire logic [4:0] SENSE_MV_O,
  input wire logic [12:0] VREG_MV_O,
  input wire logic [4:0] LED_LEVEL_O,
  input wire logic SHORT_EXT_REF_O,
  input wire logic MODE_CLEAR_O,
  input wire logic SOFT_RESET_O
);
  // ********
  // Checks
  // ********
  logic [1:0] up_r;
  // Outputs settle two edges after reset release
  always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
    if (!RSTN_I) up_r <= 2'h0;
    else up_r <= {up_r[0], 1'b1};
  end
  default clocking @(posedge CLK_SYS_I); endclocking
  default disable iff (!RSTN_I);
  sequence clr_s;
    ##[1:12] MODE_CLEAR_O;
  endsequence
  boost_clear_a: assert property ($rose(|BST_EVT_I) |-> clr_s)
    else $error("boost fault kept mode");
  chg_fault_a: assert property ($rose(|(CHG_EVT_I & CHG_FAULTS)) |-> clr_s)
    else $error("charger fault kept mode");
  rechg_clear_a: assert property ($rose(CHG_EVT_I[3]) && CHG_MODE_I == MODE_CHG |-> clr_s)
    else $error("recharge kept mode");
  rechg_keep_a: assert property ($rose(CHG_EVT_I[3]) && CHG_MODE_I != MODE_CHG |-> ##1 (!MODE_CLEAR_O) [*8])
    else $error("recharge cleared mode");
  soft_default_a: assert property (SOFT_RESET_O |-> ##[0:4] (LED_LEVEL_O == RST_LED && SHORT_EXT_REF_O))
    else $error("soft reset left values");
  input_step_a: assert property (up_r[1] |-> INPUT_REG_MV_O >= VIN_BASE && INPUT_REG_MV_O <= 13'h1298
    && (INPUT_REG_MV_O - VIN_BASE) % VIN_STEP == 13'h0) else $error("input level off grid");
  volt_cap_a: assert property (up_r[1] |-> VREG_MV_O <= 13'h1158 && VREG_MV_O >= VOUT_BASE
    && (VREG_MV_O - VOUT_BASE) % V_STEP == 13'h0) else $error("voltage off grid");
  sense_cap_a: assert property (up_r[1] |-> SENSE_MV_O <= 5'h1F && SENSE_MV_O >= LOW_CUR_MV && SENSE_MV_O[0])
    else $error("sense off grid");
  short_default_a: assert property (BATT_SHORT_I [*8] |-> ##[0:6] VREG_MV_O <= VMAX_BASE)
    else $error("short kept limits");
endmodule
`default_nettype wire

// ==== verif/chg_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module chg_host_model #(
  parameter logic [6:0] ADR = 7'h48,
  parameter int HP = 340
) (
  output logic scl_o,     // Serial clock, idles high
  output logic sda_low_o, // High pulls data low
  input wire logic sda_i  // Resolved data line
);
  // ********
  // Host
  // ********
  logic a;
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end
  // Data moves a quarter of HP after the fall so it never races the clock edge
  task automatic bt(input logic b, output logic s);
    #(HP / 4) sda_low_o = !b;
    #HP scl_o = 1'b1;
    #HP s = sda_i;
    scl_o = 1'b0;
  endtask
  task automatic xb(input logic [7:0] d, output logic [7:0] q);
    for (int i = 7; i >= 0; i--) bt(d[i], q[i]);
    bt(1'b1, a);
  endtask
  task automatic st();
    #(HP / 4) sda_low_o = 1'b0;
    #HP scl_o = 1'b1;
    #HP sda_low_o = 1'b1;
    #HP scl_o = 1'b0;
  endtask
  task automatic sp();
    #(HP / 4) sda_low_o = 1'b1;
    #HP scl_o = 1'b1;
    #HP sda_low_o = 1'b0;
    #HP;
  endtask
  task automatic wr(input logic [7:0] p, input logic [7:0] d);
    logic [7:0] q;
    st();
    xb({ADR, 1'b0}, q);
    xb(p, q);
    xb(d, q);
    sp();
  endtask
  task automatic rd(input logic [7:0] p, output logic [7:0] d);
    logic [7:0] q;
    st();
    xb({ADR, 1'b0}, q);
    xb(p, q);
    st();
    xb({ADR, 1'b1}, q);
    xb(8'hFF, d);
    sp();
  endtask
endmodule
`default_nettype wire

// ==== verif/chg_regs_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module chg_regs_tb
  import chg_pkg::*;
;
  // ********
  // Bench
  // ********
  logic CLK_SYS_I = 1'b0, LINK_CLK_I = 1'b0, RSTN_I = 1'b0, SCL_I, SDA_I, hlow, SDA_O, SDA_OE_O, EXT_WR_O;
  logic BATT_SHORT_I, HOST_PIN_I, TEMP_HOT_I, BUS_OV_I, LED_OV_I, STANDBY_I, MONITOR_ON_I, LDO_OK_I, LED_ON_I;
  logic DETECT_DONE_I, DETECT_RESULT_I, SHORT_EXT_REF_O, HOST_PIN_ACTIVE_O, TERM_EN_O, MODE_CLEAR_O, SOFT_RESET_O;
  logic [7:0] EXT_ADDR_O, EXT_WDATA_O, EXT_RDATA_I, CHG_EVT_I, v, xw;
  logic [4:0] BST_EVT_I, SENSE_MV_O, LED_LEVEL_O;
  logic [12:0] INPUT_REG_MV_O, VREG_MV_O, got, e;
  logic [5:0] VREG_CODE_I;
  logic [3:0] CHG_CODE_I;
  logic [2:0] CHG_STATE_I;
  logic [1:0] CHG_MODE_I;
  logic [31:0] r;
  logic [7:0] rv [8] = '{8'h8A, 8'h40, 8'h1F, 8'h40, 8'h01, 8'h00, 8'h00, 8'h00};
  logic [12:0] eq[$];
  string nq[$];
  event gev;
  int errors = 0, n_compared = 0, cyc = 0;
  // Open-drain data line with pull-up
  assign SDA_I = !(hlow || (SDA_OE_O && !SDA_O));
  chg_regs DUT (.*);
  chg_host_model H (.scl_o(SCL_I), .sda_low_o(hlow), .sda_i(SDA_I));
  // Keep the data of the last write to address 01 that left the bank
  always @(posedge CLK_SYS_I) begin
    if (EXT_WR_O && EXT_ADDR_O == 8'h01) xw <= EXT_WDATA_O;
  end
  initial forever #10 CLK_SYS_I = ~CLK_SYS_I;
  initial begin
    #3;
    forever #6 LINK_CLK_I = ~LINK_CLK_I;
  end
  task automatic ed(int n);
    repeat (n) @(posedge CLK_SYS_I);
    #2;
  endtask
  task automatic pchk(string n, logic [12:0] x, logic [12:0] g);
    eq.push_back(x);
    nq.push_back(n);
    got = g;
    ->gev;
    #1;
  endtask
  task automatic rchk(logic [7:0] a, logic [7:0] x);
    H.rd(a, v);
    pchk($sformatf("reg %h", a), {5'h00, x}, {5'h00, v});
  endtask
  task automatic give_verdict();
    $display("compared %0d mismatched %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(gev) begin
    n_compared++;
    if (got !== eq[0]) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nq[0], eq[0], got);
    end
    void'(eq.pop_front());
    void'(nq.pop_front());
  end
  always @(posedge CLK_SYS_I) begin
    cyc++;
    if (cyc == 90000) begin
      errors++;
      give_verdict();
    end
  end
  initial begin
    {CHG_EVT_I, BST_EVT_I, CHG_MODE_I, CHG_STATE_I, EXT_RDATA_I, BATT_SHORT_I, TEMP_HOT_I, BUS_OV_I} = '0;
    {LED_OV_I, MONITOR_ON_I, LDO_OK_I, LED_ON_I, DETECT_DONE_I, DETECT_RESULT_I} = '0;
    {STANDBY_I, HOST_PIN_I, CHG_CODE_I, VREG_CODE_I} = 12'hFFF;
    void'($urandom(32'h6BE0));
    ed(2);
    RSTN_I = 1'b1;
    ed(12);
    EXT_RDATA_I = 8'($urandom);
    pchk("vin", 13'h1108, INPUT_REG_MV_O);
    for (int i = 0; i < 8; i++) rchk(8'(A_CFG_C + i), rv[i]);
    rchk(8'h0E, EXT_RDATA_I);
    $display("reset test done");
    H.wr(A_CFG_D, 8'hAC);
    H.wr(A_CFG_C, 8'h77);
    H.wr(A_CFG_D, 8'h00);
    rchk(A_CFG_D, 8'hAC);
    pchk("vin", 13'h1298, INPUT_REG_MV_O);
    pchk("vreg", 13'h1158, VREG_MV_O);
    pchk("pin", 13'h1, HOST_PIN_ACTIVE_O);
    pchk("term", 13'h1, TERM_EN_O);
    pchk("ref", 13'h0, SHORT_EXT_REF_O);
    ed(1);
    {HOST_PIN_I, BATT_SHORT_I} = 2'h1;
    ed(12);
    BATT_SHORT_I = 1'b0;
    ed(10);
    pchk("pin", 13'h0, HOST_PIN_ACTIVE_O);
    rchk(A_CFG_D, RST_CFG_D);
    H.wr(A_CFG_D, 8'h5C);
    rchk(A_CFG_D, 8'h5C);
    ed(1);
    CHG_CODE_I = 4'($urandom);
    ed(10);
    e = (CHG_CODE_I > 4'hA) ? 13'h1F : 13'h0B + 13'(2 * CHG_CODE_I);
    pchk("sense", (e > 13'h15) ? 13'h15 : e, SENSE_MV_O);
    v = 8'($urandom);
    H.wr(A_LED, v);
    rchk(A_LED, {3'h0, v[4:0]});
    pchk("led", {8'h00, v[4:0]}, LED_LEVEL_O);
    H.wr(A_STB, 8'h80);
    rchk(A_LED, 8'h1F);
    rchk(A_STB, 8'h00);
    pchk("sense", 13'h3, SENSE_MV_O);
    H.wr(8'h01, ~v);
    pchk("ext", {5'h00, ~v}, {5'h00, xw});
    H.wr(A_CFG_D, 8'h5C);
    rchk(A_CFG_D, RST_CFG_D);
    $display("limit test done");
    ed(1);
    CHG_MODE_I = MODE_CHG;
    for (int i = 0; i < 13; i++) begin
      {BST_EVT_I, CHG_EVT_I} = 13'h1 << i;
      ed(8);
      {BST_EVT_I, CHG_EVT_I} = '0;
      ed(8);
      if (i < 8) rchk(A_CHARGER_EVENT_FLAGS, 8'h1 << i);
      else rchk(A_BOOST_FAULT_FLAGS, 8'h1 << (i - 5));
      ed(1);
    end
    rchk(A_CHARGER_EVENT_FLAGS, 8'h00);
    ed(1);
    {CHG_MODE_I, CHG_EVT_I} = {2'h3, 8'h08};
    ed(16);
    CHG_EVT_I = 8'h00;
    ed(1);
    {TEMP_HOT_I, BUS_OV_I, LED_OV_I} = 3'h7;
    ed(8);
    {BUS_OV_I, LED_OV_I} = 2'h0;
    ed(8);
    rchk(A_GENERAL_FAULT_FLAGS, 8'hC1);
    ed(1);
    TEMP_HOT_I = 1'b0;
    r = $urandom;
    {STANDBY_I, MONITOR_ON_I, CHG_STATE_I, LDO_OK_I, LED_ON_I, DETECT_DONE_I, DETECT_RESULT_I, HOST_PIN_I} = r[9:0];
    ed(8);
    rchk(A_GENERAL_FAULT_FLAGS, 8'h00);
    rchk(A_STA, {1'b0, r[9:3]});
    rchk(A_STB, {5'h00, r[2:0]});
    $display("flag test done");
    give_verdict();
  end
endmodule
bind chg_regs chg_regs_monitor u_mon (.*);
`default_nettype wire
